// ### pssr_defines.svh
// Constants of the pipelined sync SRAM port
`ifndef PSSR_DEFINES_SVH
`define PSSR_DEFINES_SVH
`define PSSR_ADDR_W    20
`define PSSR_DATA_W    32
`define PSSR_BYTES     4
`define PSSR_BURST_W   2
`define PSSR_BURST_LEN 3'h4
`define PSSR_CLK_NS    50
`endif

// ### pssr_pkg.sv
// Types of the pipelined sync SRAM port
package pssr_pkg;
	typedef enum logic {
		PSSR_LINEAR,
		PSSR_INTERLEAVED
	} pssr_order_t;
	typedef enum logic [1:0] {
		PSSR_H_IDLE,
		PSSR_H_WRITE2,
		PSSR_H_BURST,
		PSSR_H_WAIT
	} pssr_hstate_t;
endpackage

// ### pssr_bus_if.sv
// Synchronous SRAM bus between controller and memory
`timescale 1ns/1ps
`include "pssr_defines.svh"
interface pssr_bus_if;
	logic [`PSSR_ADDR_W-1:0] addr;
	logic                    ce1_n;
	logic                    ce2;
	logic                    ce3_n;
	logic                    processor_addr_strobe_n;
	logic                    controller_addr_strobe_n;
	logic                    burst_advance_n;
	logic                    global_write_n;
	logic                    byte_write_enable_n;
	logic [`PSSR_BYTES-1:0]  byte_write_select_n;
	logic                    oe_n;
	logic                    burst_mode;
	logic [`PSSR_DATA_W-1:0] dq_host_o;
	logic                    dq_host_oe_n;
	logic [`PSSR_DATA_W-1:0] dq_mem_o;
	logic                    dq_mem_oe_n;
	logic [`PSSR_DATA_W-1:0] dq;
	// Wire resolution; data bus pulled high when nobody drives it
	assign dq = !dq_mem_oe_n ? dq_mem_o : (!dq_host_oe_n ? dq_host_o : '1);
	modport mem (
		input  addr, ce1_n, ce2, ce3_n, processor_addr_strobe_n, controller_addr_strobe_n,
		input  burst_advance_n, global_write_n, byte_write_enable_n, byte_write_select_n,
		input  oe_n, burst_mode, dq,
		output dq_mem_o, dq_mem_oe_n
	);
	modport host (
		output addr, ce1_n, ce2, ce3_n, processor_addr_strobe_n, controller_addr_strobe_n,
		output burst_advance_n, global_write_n, byte_write_enable_n, byte_write_select_n,
		output oe_n, burst_mode, dq_host_o, dq_host_oe_n,
		input  dq
	);
endinterface

// ### pssr_burst_ctr.sv
// Two-bit wraparound burst address generator
`timescale 1ns/1ps
`include "pssr_defines.svh"
module pssr_burst_ctr #(
	parameter int BW = `PSSR_BURST_W
) (
	input  wire logic          clk_sys_i,
	input  wire logic          nrst_i,
	input  wire logic          load_i,
	input  wire logic [BW-1:0] start_i,
	input  wire logic          step_i,
	input  wire logic          interleaved_i,
	output logic      [BW-1:0] addr_o
);
	typedef struct packed {
		logic [BW-1:0] start;
		logic [BW-1:0] step;
	} pssr_bc_t;
	pssr_bc_t st_q;
	pssr_bc_t st_d;

	always_comb begin
		st_d = st_q;
		if (load_i) begin
			st_d.start = start_i;
			st_d.step  = '0;
		end else if (step_i) begin
			st_d.step = st_q.step + 1'b1;
		end
	end

	// Address after this edge, so a step shows its data one cycle later
	// Interleaved is xor, linear is sum modulo four
	assign addr_o = interleaved_i ? (st_d.start ^ st_d.step) : BW'(st_d.start + st_d.step);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// ### pssr_mem.sv
// Memory end: pipelined synchronous SRAM
`timescale 1ns/1ps
`include "pssr_defines.svh"
// Overview of operation
// - All synchronous inputs registered on rising edge.
// - Read data leaves through output registers.
// - Strap low linear, high or open interleaved.
// - Host holds burst strap static.
// - Strap pulled high internally.
// - Either address strobe starts an access.
// - Burst address steps only on advance.
// - Two-bit wraparound counter holds start address.
// - Byte write writes only selected bytes.
// - Global write writes all four bytes.
// - Three sync chip selects, async output enable.
// - Read needs strobe, selects, writes high.
// - Read start loads address register and counter.
// - Data drives edge after address cycle.
// - First cycle after reselect stays tri-stated.
// - Afterwards output enable decides, but a write cycle floats.
// - Back-to-back single reads supported.
// - Sampled deselect floats outputs one cycle later.
// - Both strobes active: processor strobe wins.
// - Counter advances when advance sampled low.
// - Interleaved xor, linear add modulo four.
// - Select 1 and 3 low, 2 high.
module pssr_mem #(
	parameter int AW    = `PSSR_ADDR_W,
	parameter int DEPTH = 1024
) (
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	pssr_bus_if.mem   bus,
	output logic      selected_o,
	output logic      write_seen_o
);
	localparam int DW = `PSSR_DATA_W;
	localparam int NB = `PSSR_BYTES;
	localparam int IW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [NB-1:0] bw_n;
		logic [DW-1:0] din;
		logic          processor_addr_strobe_n_n;
		logic          controller_addr_strobe_n_n;
		logic          adv_n;
		logic          gw_n;
		logic          bwe_n;
		logic          ce1_n;
		logic          ce2;
		logic          ce3_n;
		logic          mode;
	} pssr_in_t;

	typedef struct packed {
		pssr_in_t      in;
		logic [AW-1:0] areg;
		logic          sel;
		logic          processor_addr_strobe_n_wr;
		logic          wr_now;
		logic [DW-1:0] dout;
	} pssr_mem_t;

	pssr_mem_t st_q;
	pssr_mem_t st_d;
	logic [DW-1:0] array_q [DEPTH];

	logic                        strobe;
	logic                        load;
	logic                        chip_on;
	logic                        write_req;
	logic [NB-1:0]               byte_we;
	logic [`PSSR_BURST_W-1:0]    burst_lo;
	logic [AW-1:0]               cur_addr;
	logic                        step;

	// Strobe qualification on registered inputs
	always_comb begin
		chip_on   = !st_q.in.ce1_n && st_q.in.ce2 && !st_q.in.ce3_n;
		// Processor strobe ignored while select 1 is high; it wins when both active
		strobe    = (!st_q.in.processor_addr_strobe_n_n && !st_q.in.ce1_n) || !st_q.in.controller_addr_strobe_n_n;
		load      = strobe && chip_on;
		write_req = !st_q.in.gw_n || (!st_q.in.bwe_n && !(&st_q.in.bw_n));
		// Processor strobe ignores writes in its first cycle
		if (!st_q.in.processor_addr_strobe_n_n && !st_q.in.ce1_n) begin
			write_req = 1'b0;
		end
		step = !strobe && st_q.sel && !st_q.in.adv_n;
		if (!st_q.in.gw_n) begin
			byte_we = '1;
		end else if (!st_q.in.bwe_n) begin
			byte_we = ~st_q.in.bw_n;
		end else begin
			byte_we = '0;
		end
	end

	pssr_burst_ctr #(
		.BW (`PSSR_BURST_W)
	) u_burst (
		.clk_sys_i     (clk_sys_i),
		.nrst_i        (nrst_i),
		.load_i        (load),
		.start_i       (st_q.in.addr[`PSSR_BURST_W-1:0]),
		.step_i        (step),
		.interleaved_i (st_q.in.mode),
		.addr_o        (burst_lo)
	);

	// Current array address: fresh on load, else register upper bits with counter as low two bits
	assign cur_addr = load ? st_q.in.addr : {st_q.areg[AW-1:`PSSR_BURST_W], burst_lo};

	always_comb begin
		st_d = st_q;
		// Input registers
		st_d.in.addr   = bus.addr;
		st_d.in.bw_n   = bus.byte_write_select_n;
		st_d.in.din    = bus.dq;
		st_d.in.processor_addr_strobe_n_n = bus.processor_addr_strobe_n;
		st_d.in.controller_addr_strobe_n_n = bus.controller_addr_strobe_n;
		st_d.in.adv_n  = bus.burst_advance_n;
		st_d.in.gw_n   = bus.global_write_n;
		st_d.in.bwe_n  = bus.byte_write_enable_n;
		st_d.in.ce1_n  = bus.ce1_n;
		st_d.in.ce2    = bus.ce2;
		st_d.in.ce3_n  = bus.ce3_n;
		st_d.in.mode   = bus.burst_mode !== 1'b0;
		st_d.processor_addr_strobe_n_wr   = 1'b0;
		st_d.wr_now    = 1'b0;
		if (load) begin
			st_d.areg  = st_q.in.addr;
			st_d.sel   = 1'b1;
			st_d.wr_now = write_req;
		end else if (strobe) begin
			st_d.sel = 1'b0;
		end else if (st_q.sel) begin
			st_d.wr_now = write_req;
		end
		st_d.dout = array_q[cur_addr[IW-1:0]];
	end

	always_ff @(posedge clk_sys_i) begin
		for (int b = 0; b < NB; b++) begin
			if (st_q.sel && !load && !strobe && byte_we[b]) begin
				array_q[cur_addr[IW-1:0]][b*8 +: 8] <= st_q.in.din[b*8 +: 8];
			end
		end
		if (load && !(!st_q.in.processor_addr_strobe_n_n && !st_q.in.ce1_n)) begin
			for (int b = 0; b < NB; b++) begin
				if (byte_we[b]) begin
					array_q[cur_addr[IW-1:0]][b*8 +: 8] <= st_q.in.din[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.dq_mem_o = st_q.dout;
	// Async enable; reselect cycle still has sel low, so it floats
	assign bus.dq_mem_oe_n = !(st_q.sel && !st_q.wr_now && !bus.oe_n);
	assign selected_o   = st_q.sel;
	assign write_seen_o = st_q.wr_now;
endmodule

// ### pssr_host.sv
// Controller end: drives the synchronous SRAM bus
`timescale 1ns/1ps
`include "pssr_defines.svh"
module pssr_host #(
	parameter int AW = `PSSR_ADDR_W
) (
	input  wire logic                    clk_sys_i,
	input  wire logic                    nrst_i,
	pssr_bus_if.host                     bus,
	input  wire logic                    req_i,
	input  wire logic                    req_write_i,
	input  wire logic                    req_burst_i,
	input  wire logic                    req_use_proc_i,
	input  wire logic [AW-1:0]           req_addr_i,
	input  wire logic [`PSSR_DATA_W-1:0] req_wdata_i,
	input  wire logic [`PSSR_BYTES-1:0]  req_bytes_i,
	input  wire logic                    interleaved_i,
	output logic                         req_ready_o,
	output logic                         rd_valid_o,
	output logic [`PSSR_DATA_W-1:0]      rd_data_o
);
	typedef struct packed {
		pssr_pkg::pssr_hstate_t   state;
		logic                     strap;
		logic                     strap_done;
		logic [AW-1:0]            addr;
		logic                     ce_on;
		logic                     processor_addr_strobe_n_n;
		logic                     controller_addr_strobe_n_n;
		logic                     adv_n;
		logic                     gw_n;
		logic                     bwe_n;
		logic [`PSSR_BYTES-1:0]   bytes;
		logic [`PSSR_DATA_W-1:0]  wdata;
		logic                     wr;
		logic                     rd_p1;
		logic                     rd_p2;
		logic [2:0]               beats;
		logic                     rd_valid;
		logic [`PSSR_DATA_W-1:0]  rd_data;
	} pssr_host_t;

	pssr_host_t st_q;
	pssr_host_t st_d;

	assign req_ready_o = st_q.state == pssr_pkg::PSSR_H_IDLE;

	always_comb begin
		st_d          = st_q;
		st_d.processor_addr_strobe_n_n   = 1'b1;
		st_d.controller_addr_strobe_n_n   = 1'b1;
		st_d.adv_n    = 1'b1;
		st_d.gw_n     = 1'b1;
		st_d.bwe_n    = 1'b1;
		st_d.rd_valid = 1'b0;
		// Strap latched once after reset, then held
		if (!st_q.strap_done) begin
			st_d.strap      = interleaved_i;
			st_d.strap_done = 1'b1;
		end
		// Read beat on the pins: data stands two edges later; deselect excluded
		st_d.rd_p1 = st_q.ce_on && !st_q.wr && (!st_q.controller_addr_strobe_n_n || !st_q.processor_addr_strobe_n_n || !st_q.adv_n);
		st_d.rd_p2 = st_q.rd_p1;
		unique case (st_q.state)
			pssr_pkg::PSSR_H_IDLE: begin
				st_d.wr = 1'b0;
				if (req_i) begin
					st_d.addr  = req_addr_i;
					st_d.ce_on = 1'b1;
					st_d.wdata = req_wdata_i;
					st_d.wr    = req_write_i;
					st_d.bytes = req_bytes_i;
					st_d.beats = req_burst_i ? `PSSR_BURST_LEN - 3'h1 : 3'h0;
					if (req_use_proc_i) begin
						st_d.processor_addr_strobe_n_n = 1'b0;
						st_d.state  = req_write_i ? pssr_pkg::PSSR_H_WRITE2 :
							(req_burst_i ? pssr_pkg::PSSR_H_BURST : pssr_pkg::PSSR_H_WAIT);
					end else begin
						st_d.controller_addr_strobe_n_n = 1'b0;
						st_d.gw_n   = !(req_write_i && &req_bytes_i);
						st_d.bwe_n  = !(req_write_i && !(&req_bytes_i));
						st_d.state  = req_burst_i ? pssr_pkg::PSSR_H_BURST : pssr_pkg::PSSR_H_WAIT;
					end
				end
			end
			pssr_pkg::PSSR_H_WRITE2: begin
				st_d.gw_n  = !(&st_q.bytes);
				st_d.bwe_n = &st_q.bytes;
				st_d.state = st_q.beats != 3'h0 ? pssr_pkg::PSSR_H_BURST : pssr_pkg::PSSR_H_WAIT;
			end
			pssr_pkg::PSSR_H_BURST: begin
				st_d.adv_n = 1'b0;
				st_d.gw_n  = !(st_q.wr && &st_q.bytes);
				st_d.bwe_n = !(st_q.wr && !(&st_q.bytes));
				st_d.beats = st_q.beats - 3'h1;
				if (st_q.beats == 3'h1) begin
					st_d.state = pssr_pkg::PSSR_H_WAIT;
				end
			end
			pssr_pkg::PSSR_H_WAIT: begin
				// Deselect via controller strobe with select 1 high
				st_d.ce_on  = 1'b0;
				st_d.controller_addr_strobe_n_n = 1'b0;
				st_d.state  = pssr_pkg::PSSR_H_IDLE;
			end
		endcase
		if (st_q.rd_p2) begin
			st_d.rd_valid = 1'b1;
			st_d.rd_data  = bus.dq;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '{state: pssr_pkg::PSSR_H_IDLE, processor_addr_strobe_n_n: 1'b1, controller_addr_strobe_n_n: 1'b1, adv_n: 1'b1,
				gw_n: 1'b1, bwe_n: 1'b1, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.addr                     = st_q.addr;
	assign bus.ce1_n                    = !st_q.ce_on;
	assign bus.ce2                      = 1'b1;
	assign bus.ce3_n                    = 1'b0;
	assign bus.processor_addr_strobe_n  = st_q.processor_addr_strobe_n_n;
	assign bus.controller_addr_strobe_n = st_q.controller_addr_strobe_n_n;
	assign bus.burst_advance_n          = st_q.adv_n;
	assign bus.global_write_n           = st_q.gw_n;
	assign bus.byte_write_enable_n      = st_q.bwe_n;
	assign bus.byte_write_select_n      = ~st_q.bytes;
	assign bus.oe_n                     = st_q.wr;
	assign bus.burst_mode               = st_q.strap;
	assign bus.dq_host_o                = st_q.wdata;
	assign bus.dq_host_oe_n             = !st_q.wr;
	assign rd_valid_o                   = st_q.rd_valid;
	assign rd_data_o                    = st_q.rd_data;
endmodule

// ### pssr_sva.sv
// Checker of the SRAM bus between controller and memory ends
`timescale 1ns/1ps
module pssr_sva (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce1_n,
	input wire logic ce2,
	input wire logic ce3_n,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic oe_n,
	input wire logic burst_mode,
	input wire logic dq_host_oe_n,
	input wire logic dq_mem_oe_n
);
	// =====================
	// Bus decode
	logic       sel, stb, rd_c, wr_c, desel;
	logic [1:0] st_q;
	assign sel   = !ce1_n && ce2 && !ce3_n;
	assign stb   = !controller_addr_strobe_n || (!processor_addr_strobe_n && !ce1_n);
	assign rd_c  = sel && !controller_addr_strobe_n && processor_addr_strobe_n && global_write_n && byte_write_enable_n;
	assign wr_c  = stb && sel && !(global_write_n && byte_write_enable_n);
	assign desel = stb && !sel;
	// Selection state: 0 unknown, 1 deselected, 2 selected
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			st_q <= 2'h0;
		else if (desel)
			st_q <= 2'h1;
		else if (stb)
			st_q <= 2'h2;
	end
	// =====================
	// Properties
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence quiet_s;
		!wr_c;
	endsequence
	sequence data_cycle_s;
		quiet_s ##1 !oe_n;
	endsequence
	read_drive_a: assert property (rd_c ##1 data_cycle_s |-> !dq_mem_oe_n)
		else $error("read data not driven");
	reselect_mask_a: assert property (rd_c && st_q == 2'h1 |-> ##1 dq_mem_oe_n)
		else $error("first cycle after reselect driven");
	deselect_float_a: assert property (desel |-> ##[1:2] dq_mem_oe_n)
		else $error("no float after deselect");
	idle_float_a: assert property (st_q == 2'h1 && !stb |-> ##2 dq_mem_oe_n)
		else $error("deselected memory drives");
	oe_gate_a: assert property (oe_n |-> dq_mem_oe_n)
		else $error("drive while output enable high");
	no_contention_a: assert property (!dq_host_oe_n |-> dq_mem_oe_n)
		else $error("both ends drive data");
	host_oe_a: assert property (!dq_host_oe_n |-> oe_n)
		else $error("host drives with output enable low");
	strap_static_a: assert property (1'h1 |-> ##3 $stable(burst_mode))
		else $error("burst strap changed");
endmodule

// ### tb_pipelined_sync_sram_read_port.sv
// Bench joining controller and memory ends over the SRAM bus
`timescale 1ns/1ps
`include "pssr_defines.svh"
module tb_pipelined_sync_sram_read_port;
	localparam logic [19:0] BASE = 20'h00040;
	logic                    clk_sys_i;
	logic                    nrst_i;
	logic                    req_i;
	logic                    req_write_i;
	logic                    req_burst_i;
	logic                    req_use_proc_i;
	logic [`PSSR_ADDR_W-1:0] req_addr_i;
	logic [`PSSR_DATA_W-1:0] req_wdata_i;
	logic [`PSSR_BYTES-1:0]  req_bytes_i;
	logic                    interleaved_i;
	logic                    req_ready_o;
	logic                    rd_valid_o;
	logic [`PSSR_DATA_W-1:0] rd_data_o;
	int                      n_errors;
	int                      n_compared;
	int                      cycles;
	pssr_bus_if bus ();
	pssr_mem i_pssr_mem (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(bus), .selected_o(), .write_seen_o());
	pssr_host i_pssr_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(bus), .req_i(req_i),
		.req_write_i(req_write_i), .req_burst_i(req_burst_i), .req_use_proc_i(req_use_proc_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_bytes_i(req_bytes_i),
		.interleaved_i(interleaved_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
	pssr_sva i_pssr_sva (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce1_n(bus.ce1_n), .ce2(bus.ce2),
		.ce3_n(bus.ce3_n), .processor_addr_strobe_n(bus.processor_addr_strobe_n),
		.controller_addr_strobe_n(bus.controller_addr_strobe_n), .global_write_n(bus.global_write_n),
		.byte_write_enable_n(bus.byte_write_enable_n), .oe_n(bus.oe_n), .burst_mode(bus.burst_mode),
		.dq_host_oe_n(bus.dq_host_oe_n), .dq_mem_oe_n(bus.dq_mem_oe_n));
	// =====================
	// Shared tasks
	function automatic logic [31:0] pat(input logic [19:0] a);
		return {12'hC3A, a};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic reset_dut(input logic mode);
		@(posedge clk_sys_i);
		nrst_i <= 1'h0;
		interleaved_i <= mode;
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'h1;
	endtask
	task automatic issue(input logic wr, input logic bst, input logic proc, input logic [19:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		req_i <= 1'h1;
		req_write_i <= wr;
		req_burst_i <= bst;
		req_use_proc_i <= proc;
		req_addr_i <= a;
		req_wdata_i <= d;
		req_bytes_i <= be;
		@(negedge clk_sys_i);
		while (req_ready_o !== 1'h1 && n < 100) begin
			n++;
			@(negedge clk_sys_i);
		end
		@(posedge clk_sys_i);
		req_i <= 1'h0;
	endtask
	task automatic expect_rd(input logic [31:0] exp);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		while (rd_valid_o !== 1'h1 && n < 100) begin
			n++;
			@(negedge clk_sys_i);
		end
		check(rd_data_o, exp);
	endtask
	// =====================
	// Scenarios
	task automatic s_write_read(input logic proc);
		for (int i = 0; i < 4; i++)
			issue(1'h1, 1'h0, proc, BASE + 20'(i), pat(BASE + 20'(i)), 4'hF);
		for (int i = 0; i < 4; i++) begin
			issue(1'h0, 1'h0, !proc, BASE + 20'(i), 32'h0, 4'h0);
			expect_rd(pat(BASE + 20'(i)));
		end
	endtask
	task automatic s_bytes();
		logic [3:0] m;
		for (int b = 0; b < 16; b++) begin
			m = 4'(b);
			issue(1'h1, 1'h0, 1'h0, BASE, 32'h0, 4'hF);
			issue(1'h1, 1'h0, m[0], BASE, 32'hFFFFFFFF, m);
			issue(1'h0, 1'h0, m[1], BASE, 32'h0, 4'h0);
			expect_rd({{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}});
		end
	endtask
	task automatic s_burst(input logic mode);
		logic [1:0] k;
		reset_dut(mode);
		for (int i = 0; i < 4; i++)
			issue(1'h1, 1'h0, 1'h0, BASE + 20'(i), pat(BASE + 20'(i)), 4'hF);
		for (int s = 0; s < 4; s++) begin
			issue(1'h0, 1'h1, s[0], BASE + 20'(s), 32'h0, 4'h0);
			for (int j = 0; j < 4; j++) begin
				k = mode ? 2'(s ^ j) : 2'(s + j);
				expect_rd(pat(BASE + 20'(k)));
			end
		end
	endtask
	// =====================
	// Clock, timeout and main sequence
	initial begin
		clk_sys_i = 1'h0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		{nrst_i, req_i, req_write_i, req_burst_i, req_use_proc_i} = 5'h0;
		req_addr_i = 20'h0;
		req_wdata_i = 32'h0;
		req_bytes_i = 4'h0;
		interleaved_i = 1'h1;
		n_errors = 0;
		n_compared = 0;
		cycles = 0;
		reset_dut(1'h1);
		s_write_read(1'h0);
		s_write_read(1'h1);
		s_bytes();
		s_burst(1'h1);
		s_burst(1'h0);
		final_report();
	end
endmodule
